// ===== pct_map.svh
// register map, field positions and reset values of the countdown timer
//
// Contract
// RL1: six-bit prescaler divides clock by one to 64
// RL2: counter decrements per prescaler overflow, range 1-256
// RL3: request only when counter and prescaler both end
// RL4: software starts, stops, resumes or restarts counting
// RL5: mode 0 halts at zero, 1 reloads
// RL6: count read is harmless; prescaler unreadable
// RL7: counter write stores initial value, 00 means 256
// RL8: prescaler byte: mode, reserved zero, ratio 00=64
// RL9: counting continues while processor is halted
// RL10: oscillator stop freezes timer, no wake-up
// RL11: load bit presets counter and prescaler; enable gates
// RL12: after reset disabled, no request
`ifndef PCT_MAP_SVH
`define PCT_MAP_SVH

// register file addresses
`define PCT_ADDR_MODE      8'hF1
`define PCT_ADDR_PRESC     8'hF5
`define PCT_ADDR_COUNT     8'hF2

// timer mode control fields
`define PCT_MODE_LOAD_BIT  0
`define PCT_MODE_EN_BIT    1
`define PCT_MODE_RUN_BIT   2
`define PCT_MODE_DONE_BIT  3

// prescaler config fields
`define PCT_PRE_CMODE_BIT  0
`define PCT_PRE_RSVD_BIT   1
`define PCT_PRE_RATIO_LSB  2
`define PCT_PRE_RATIO_MSB  7

// reset values
`define PCT_INIT_RST       8'h00
`define PCT_RATIO_RST      6'h00
`define PCT_COUNT_RST      8'h00
`define PCT_RDATA_RST      8'h00

`endif

// ===== pct_pkg.sv
// types shared by the countdown timer modules
package pct_pkg;

  // counter activity states
  typedef enum logic [1:0] {
    pct_idle,
    pct_run,
    pct_frozen,
    pct_done
  } pct_state_e;

  typedef logic [7:0] pct_byte_t;
  typedef logic [5:0] pct_ratio_t;

endpackage : pct_pkg

// ===== pct_presc_if.sv
// signals between the timer control and its prescaler
`timescale 1ns/10ps
`default_nettype none

interface pct_presc_if;
  logic            preset;
  logic            run;
  pct_pkg::pct_ratio_t ratio;
  logic            tick;

  // control side
  modport ctrl (
    output preset,
    output run,
    output ratio,
    input  tick
  );

  // prescaler side
  modport presc (
    input  preset,
    input  run,
    input  ratio,
    output tick
  );
endinterface : pct_presc_if

`default_nettype wire

// ===== pct_prescaler.sv
// six-bit programmable prescaler of the countdown timer
`timescale 1ns/10ps
`default_nettype none
`include "pct_map.svh"

module pct_prescaler (
  // clock and reset
  input  wire logic    ref_clk,
  input  wire logic    rst_n,
  // link to the timer control
  pct_presc_if.presc   pif
);

  // remaining clocks of this period, 0 stands for 64
  pct_pkg::pct_ratio_t remain;

  // end of count when one clock is left
  assign pif.tick = pif.run && (remain == 6'h01); // [RL1]

  // reload on preset or on end of count, else count down
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      remain <= `PCT_RATIO_RST;
    end else if (pif.preset) begin
      remain <= pif.ratio; // [RL11]
    end else if (pif.tick) begin
      remain <= pif.ratio; // [RL1]
    end else if (pif.run) begin
      remain <= remain - 6'h01; // 0 wraps to 63, giving 64 [RL1]
    end
  end

endmodule : pct_prescaler

`default_nettype wire

// ===== pct_timer.sv
// prescaled countdown timer with its register file port
`timescale 1ns/10ps
`default_nettype none
`include "pct_map.svh"

module pct_timer (
  // clock and reset
  input  wire logic   ref_clk,
  input  wire logic   rst_n,
  // register file access from the core
  input  wire logic   reg_wr,
  input  wire logic   reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output var  logic [7:0] reg_rdata,
  // power state of the oscillator
  input  wire logic   osc_stop,
  // timer outputs
  output var  logic   timer_interrupt_request,
  output var  logic   timer_running
);

  ////////////////////////////////////////////////////////////
  // declarations
  ////////////////////////////////////////////////////////////

  pct_presc_if         pif ();

  pct_pkg::pct_byte_t  init_value;
  pct_pkg::pct_byte_t  countdown_timer;
  pct_pkg::pct_ratio_t ratio;
  logic                modulo_mode;
  logic                enable;
  logic                done_flag;
  pct_pkg::pct_state_e state;
  pct_pkg::pct_state_e next_state;

  logic                wr_mode;
  logic                wr_presc;
  logic                wr_count;
  logic                rd_mode;
  logic                rd_count;
  logic                load_req;
  logic                en_req;
  logic                tick;
  logic                end_count;
  logic                counting;

  ////////////////////////////////////////////////////////////
  // helper functions
  ////////////////////////////////////////////////////////////

  // address match for one register
  function automatic logic hit(input logic [7:0] addr,
                               input logic [7:0] reg_addr_c);
    hit = (addr == reg_addr_c);
  endfunction : hit

  // mode register readback image
  function automatic pct_pkg::pct_byte_t mode_image(
      input logic en_c,
      input logic run_c,
      input logic done_c);
    pct_pkg::pct_byte_t img;
    img = 8'h00;
    img[`PCT_MODE_EN_BIT]   = en_c;
    img[`PCT_MODE_RUN_BIT]  = run_c;
    img[`PCT_MODE_DONE_BIT] = done_c;
    mode_image = img;
  endfunction : mode_image

  ////////////////////////////////////////////////////////////
  // register decode
  ////////////////////////////////////////////////////////////

  // write strobes per register, read strobes for mode and count
  assign wr_mode  = reg_wr && hit(reg_addr, `PCT_ADDR_MODE);
  assign wr_presc = reg_wr && hit(reg_addr, `PCT_ADDR_PRESC);
  assign wr_count = reg_wr && hit(reg_addr, `PCT_ADDR_COUNT);
  assign rd_mode  = reg_rd && hit(reg_addr, `PCT_ADDR_MODE);
  assign rd_count = reg_rd && hit(reg_addr, `PCT_ADDR_COUNT);

  // control bits of a mode write
  assign load_req = wr_mode && reg_wdata[`PCT_MODE_LOAD_BIT]; // [RL11]
  assign en_req   = reg_wdata[`PCT_MODE_EN_BIT];

  ////////////////////////////////////////////////////////////
  // programmed values
  ////////////////////////////////////////////////////////////

  // initial count, 00 stands for 256
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      init_value <= `PCT_INIT_RST;
    end else if (wr_count) begin
      init_value <= reg_wdata; // [RL7]
    end
  end

  // prescaler config, reserved bit ignored
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      modulo_mode <= 1'b0;
      ratio       <= `PCT_RATIO_RST;
    end else if (wr_presc) begin
      modulo_mode <= reg_wdata[`PCT_PRE_CMODE_BIT]; // [RL8]
      ratio       <= reg_wdata[`PCT_PRE_RATIO_MSB:`PCT_PRE_RATIO_LSB]; // [RL8]
    end
  end

  // software enable, only a mode write changes it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable <= 1'b0; // [RL12]
    end else if (wr_mode) begin
      enable <= en_req; // [RL4]
    end
  end

  ////////////////////////////////////////////////////////////
  // prescaler
  ////////////////////////////////////////////////////////////

  // drive the prescaler link
  assign counting   = (state == pct_pkg::pct_run);
  assign pif.run    = counting; // [RL11]
  assign pif.preset = load_req; // [RL11]
  assign pif.ratio  = ratio;
  assign tick       = pif.tick;

  pct_prescaler u_presc (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pif     (pif.presc)
  );

  // both stages at end of count together
  assign end_count = tick && (countdown_timer == 8'h01); // [RL3]

  ////////////////////////////////////////////////////////////
  // down-counter
  ////////////////////////////////////////////////////////////

  // load, decrement on overflow, reload in modulo mode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      countdown_timer <= `PCT_COUNT_RST;
    end else if (load_req) begin
      countdown_timer <= init_value; // restart from initial [RL4]
    end else if (end_count) begin
      if (modulo_mode) begin
        countdown_timer <= init_value; // [RL5]
      end else begin
        countdown_timer <= 8'h00; // [RL5]
      end
    end else if (tick) begin
      countdown_timer <= countdown_timer - 8'h01; // 00 -> FF [RL2]
    end
  end

  ////////////////////////////////////////////////////////////
  // activity state
  ////////////////////////////////////////////////////////////

  // next state of the counter
  always_comb begin
    next_state = state;
    case (state)
      pct_pkg::pct_idle: begin
        if (wr_mode && en_req && !osc_stop) begin
          next_state = pct_pkg::pct_run; // start or resume [RL4]
        end
      end
      pct_pkg::pct_run: begin
        if (wr_mode && !en_req) begin
          next_state = pct_pkg::pct_idle; // stop [RL4]
        end else if (end_count && !modulo_mode && !load_req) begin
          next_state = pct_pkg::pct_done; // [RL5]
        end else if (osc_stop) begin
          next_state = pct_pkg::pct_frozen; // [RL10]
        end
      end
      pct_pkg::pct_frozen: begin
        if (wr_mode && !en_req) begin
          next_state = pct_pkg::pct_idle;
        end else if (!osc_stop) begin
          next_state = pct_pkg::pct_run; // [RL10]
        end
      end
      pct_pkg::pct_done: begin
        if (wr_mode && !en_req) begin
          next_state = pct_pkg::pct_idle;
        end else if (wr_mode && en_req && !osc_stop) begin
          next_state = pct_pkg::pct_run; // rerun after single pass [RL4]
        end
      end
      default: begin
        next_state = pct_pkg::pct_idle;
      end
    endcase
  end

  // state register; processor halt is not seen here
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pct_pkg::pct_idle; // [RL12]
    end else begin
      state <= next_state; // [RL9]
    end
  end

  // single pass finished, set wins over a load
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_flag <= 1'b0;
    end else if (end_count && !modulo_mode) begin
      done_flag <= 1'b1; // [RL5]
    end else if (load_req) begin
      done_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////
  // outputs
  ////////////////////////////////////////////////////////////

  // one-cycle request at the joint end of count
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_interrupt_request <= 1'b0; // [RL12]
    end else begin
      timer_interrupt_request <= end_count; // [RL3]
    end
  end

  // running status, registered
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_running <= 1'b0;
    end else begin
      timer_running <= (next_state == pct_pkg::pct_run);
    end
  end

  // read data, held until the next read
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `PCT_RDATA_RST;
    end else if (rd_count) begin
      reg_rdata <= countdown_timer; // live value, no side effect [RL6]
    end else if (rd_mode) begin
      reg_rdata <= mode_image(enable, counting, done_flag);
    end else if (reg_rd) begin
      reg_rdata <= 8'h00; // prescaler and unmapped read as zero [RL6]
    end
  end

endmodule : pct_timer

`default_nettype wire

// ===== pct_timer_sva.sv
// assertion checker on the countdown timer ports
`timescale 1ns/10ps
`default_nettype none
`include "pct_map.svh"

module pct_timer_sva (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // register port
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // power state and outputs
  input wire logic       osc_stop,
  input wire logic       timer_interrupt_request,
  input wire logic       timer_running
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic mode_wr;
  logic en_seen;
  // a write to the mode register
  assign mode_wr = reg_wr && reg_addr == `PCT_ADDR_MODE;
  // remembers any enable write since reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      en_seen <= 1'b0;
    else if (mode_wr && reg_wdata[`PCT_MODE_EN_BIT])
      en_seen <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////
  idle_after_rst_a: assert property (timer_running || timer_interrupt_request |-> en_seen)
    else $error("timer active before any enable write");
  irq_in_run_a: assert property (timer_interrupt_request |-> $past(timer_running))
    else $error("request without a running count");
  // a request may still come from the last counting edge, so two stopped samples are needed
  frozen_quiet_a: assert property ($past(osc_stop) && $past(osc_stop, 2) |-> !timer_interrupt_request)
    else $error("request while oscillator stopped");
  stop_write_a: assert property (mode_wr && !reg_wdata[`PCT_MODE_EN_BIT] |=> !timer_running)
    else $error("counting went on after disable");
  start_write_a: assert property (mode_wr && reg_wdata[`PCT_MODE_EN_BIT] && !osc_stop |=> ##[0:1] timer_running)
    else $error("counting did not start after enable");
  rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  presc_hidden_a: assert property (reg_rd && reg_addr == `PCT_ADDR_PRESC |=> reg_rdata == 8'h00)
    else $error("prescaler value readable");
  mode_status_a: assert property (reg_rd && reg_addr == `PCT_ADDR_MODE |=>
    reg_rdata[`PCT_MODE_RUN_BIT] == $past(timer_running) && reg_rdata[0] == 1'b0 && reg_rdata[7:4] == 4'h0)
    else $error("mode read status wrong");
  // main scenarios reached
  irq_seen_c: cover property (timer_interrupt_request);
  freeze_c: cover property (osc_stop && $past(timer_running));
  count_rd_c: cover property (reg_rd && reg_addr == `PCT_ADDR_COUNT);
endmodule : pct_timer_sva

bind pct_timer pct_timer_sva u_sva (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .osc_stop(osc_stop),
  .timer_interrupt_request(timer_interrupt_request), .timer_running(timer_running));

`default_nettype wire

// ===== pct_core_model.sv
// processor core model driving the timer register port
`timescale 1ns/10ps
`default_nettype none
`include "pct_map.svh"

module pct_core_model (
  // clock
  input  wire logic       ref_clk,
  // register port
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic [7:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // bus idle at time zero
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one write pulse, reserved prescaler bit kept zero
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= (a == `PCT_ADDR_PRESC) ? (d & 8'hFD) : d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a; // released bus shows no stale value
    reg_wdata <= ~d;
  endtask : wr
  // one read pulse, data taken a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge ref_clk);
    d = reg_rdata;
  endtask : rd
endmodule : pct_core_model

`default_nettype wire

// ===== pct_timer_tb_top.sv
// self-checking testbench of the countdown timer
`timescale 1ns/10ps
`default_nettype none

module pct_timer_tb_top;
  logic       ref_clk, rst_n, osc_stop, reg_wr, reg_rd, timer_interrupt_request, timer_running;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, r1, r2;
  int         miscompares, n_tests, gap;
  pct_timer uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .osc_stop(osc_stop),
    .timer_interrupt_request(timer_interrupt_request), .timer_running(timer_running));
  pct_core_model core (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  // edges until the next request pulse, bounded
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (timer_interrupt_request !== 1'b1 && n < 2000);
  endtask : wait_irq
  ////////////////////////////////////////////////////////////////////////
  // quiet after reset, hidden and unmapped places
  task automatic t_reset();
    chk("irq", {15'h0, timer_interrupt_request}, 16'h0000);
    chk("run", {15'h0, timer_running}, 16'h0000);
    core.wr(8'hF3, 8'hFF);
    core.rd(8'hF1, r1);
    chk("mode", {8'h00, r1}, 16'h0000);
    core.rd(8'hF5, r1);
    chk("presc", {8'h00, r1}, 16'h0000);
  endtask : t_reset
  // modulo periods at ratio and count boundaries
  task automatic t_modulo();
    logic [7:0]  pre_t [4] = '{8'h09, 8'h05, 8'h05, 8'h01};
    logic [7:0]  ini_t [4] = '{8'h03, 8'h00, 8'h01, 8'h02};
    logic [15:0] per_t [4] = '{16'h0006, 16'h0100, 16'h0001, 16'h0080};
    for (int i = 0; i < 4; i++) begin
      core.wr(8'hF5, pre_t[i]);
      core.wr(8'hF2, ini_t[i]);
      core.wr(8'hF1, 8'h03);
      wait_irq(gap);
      wait_irq(gap);
      chk("period", 16'(gap), per_t[i]);
      core.rd(8'hF1, r1);
      chk("mode run", {8'h00, r1}, 16'h0006);
      core.wr(8'hF1, 8'h00);
    end
  endtask : t_modulo
  // single pass ends once at zero
  task automatic t_single();
    core.wr(8'hF5, 8'h00);
    core.wr(8'hF2, 8'h05);
    core.wr(8'hF1, 8'h03);
    core.rd(8'hF2, r1);
    chk("loaded", {8'h00, r1}, 16'h0005);
    wait_irq(gap);
    chk("single end", {15'h0, gap < 2000}, 16'h0001);
    repeat (3) @(posedge ref_clk);
    chk("halted", {15'h0, timer_running}, 16'h0000);
    core.rd(8'hF2, r1);
    chk("zero", {8'h00, r1}, 16'h0000);
    core.rd(8'hF1, r1);
    chk("done", {8'h00, r1}, 16'h000A);
    wait_irq(gap);
    chk("no reload", {15'h0, timer_interrupt_request}, 16'h0000);
    core.wr(8'hF1, 8'h00);
  endtask : t_single
  // stop, resume and oscillator freeze
  task automatic t_stop();
    core.wr(8'hF5, 8'h05);
    core.wr(8'hF2, 8'h00);
    core.wr(8'hF1, 8'h03);
    repeat (5) @(posedge ref_clk);
    core.wr(8'hF1, 8'h00);
    core.rd(8'hF2, r1);
    core.rd(8'hF2, r2);
    chk("stopped", {8'h00, r2}, {8'h00, r1});
    core.wr(8'hF1, 8'h02);
    core.rd(8'hF2, r2);
    chk("resumed", {15'h0, r2 < r1}, 16'h0001);
    chk("running", {15'h0, timer_running}, 16'h0001);
    osc_stop <= 1'b1;
    core.rd(8'hF2, r1);
    core.rd(8'hF2, r2);
    chk("frozen", {8'h00, r2}, {8'h00, r1});
    chk("frozen run", {15'h0, timer_running}, 16'h0000);
    osc_stop <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("thawed", {15'h0, timer_running}, 16'h0001);
    core.wr(8'hF1, 8'h00);
  endtask : t_stop
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n = 1'b0;
    osc_stop = 1'b0;
    miscompares = 0;
    n_tests = 0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_modulo();
    t_single();
    t_stop();
    results();
  end
  // watchdog against a hang
  initial begin
    #2000000;
    miscompares++;
    results();
  end
endmodule : pct_timer_tb_top

`default_nettype wire
